// >>> design/cise_channel.sv
// One channel: enable bits, change detection and clear-on-read status flags.
// Assumes condition inputs are already synchronous to clk.
`timescale 1ns/1ps
`include "cise_params.svh"

module cise_channel (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register access
  input wire logic en_wr,
  input wire cise_pkg::cise_src_t en_wdata,
  input wire logic st_rd,
  // Conditions, bit order fifo, lock, signal, drive
  input wire cise_pkg::cise_src_t cond,
  // State
  output cise_pkg::cise_src_t enable,
  output cise_pkg::cise_src_t status,
  output logic irq
);

  cise_pkg::cise_src_t en_q;
  cise_pkg::cise_src_t st_q;
  cise_pkg::cise_src_t cond_q;
  logic prime_q;
  cise_pkg::cise_src_t change;

  // =====================================================
  // Enable register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en_q <= `CISE_EN_RESET;
    end else if (en_wr) begin
      en_q <= en_wdata;
    end
  end

  // =====================================================
  // Change detection, both edges of each condition
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cond_q <= `CISE_ST_RESET;
      prime_q <= 1'b0;
    end else begin
      cond_q <= cond;
      prime_q <= 1'b1;
    end
  end

  // First cycle after reset only loads the history
  assign change = prime_q ? (cond ^ cond_q) : `CISE_ST_RESET;

  // =====================================================
  // Status flags, a new change wins over the read clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= `CISE_ST_RESET;
    end else if (st_rd) begin
      st_q <= change;
    end else begin
      st_q <= st_q | change;
    end
  end

  assign enable = en_q;
  assign status = st_q;
  assign irq = |(st_q & en_q);

endmodule

// >>> design/cise_params.svh
// Register offsets, field positions and reset values for the channel source interrupt block.
// Assumes a register address bus of 6 bits and 8-bit register data.
`ifndef CISE_PARAMS_SVH
`define CISE_PARAMS_SVH

`define CISE_ADDR_W 6
`define CISE_DATA_W 8
`define CISE_NUM_CH 3
`define CISE_NUM_SRC 4

// Channel 0, 1, 2 source enable registers
`define CISE_EN_CH0_ADDR 6'h01
`define CISE_EN_CH1_ADDR 6'h09
`define CISE_EN_CH2_ADDR 6'h11
// Matching clear-on-read status registers
`define CISE_ST_CH0_ADDR 6'h02
`define CISE_ST_CH1_ADDR 6'h0a
`define CISE_ST_CH2_ADDR 6'h12

// Field positions within both registers
`define CISE_BIT_FIFO_LIMIT 3
`define CISE_BIT_LOCK_LOST 2
`define CISE_BIT_SIGNAL_LOST 1
`define CISE_BIT_DRIVE_MON 0

`define CISE_EN_RESET 4'h0
`define CISE_ST_RESET 4'h0
`define CISE_COND_IDLE 1'b0
`define CISE_UPPER_ZERO 4'h0
`define CISE_RD_UNMAPPED 8'h00

`endif

// >>> design/cise_pkg.sv
// Types shared by the channel source interrupt block.
// Assumes nothing beyond the constants header.
package cise_pkg;
  typedef logic [3:0] cise_src_t;
  typedef logic [7:0] cise_byte_t;
endpackage

// >>> design/cise_top.sv
// Channel source interrupt enables and clear-on-read status for three channels.
// Assumes a synchronous register port on clk and asynchronous condition inputs.
// Assumes reg_rd and reg_wr are never high in the same cycle.
//
// Contract
// - Each of three channels has its own enable register at 0x01, 0x09, 0x11.
// - Enable bit 3 lets fifo limit alarm changes raise an interrupt.
// - Enable bit 2 lets receive lock lost changes raise an interrupt.
// - Enable bit 1 lets receive signal lost changes raise an interrupt.
// - Enable bit 0 lets transmit drive monitor changes raise an interrupt.
// - Enable bits read/write, reset zero; upper four bits read zero.
// - Status registers at 0x02, 0x0A, 0x12 latch changes; reset zero.
// - Reading status returns flags then clears them.
`timescale 1ns/1ps
`include "cise_params.svh"

module cise_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [`CISE_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`CISE_DATA_W-1:0] reg_wdata,
  output logic [`CISE_DATA_W-1:0] reg_rdata,
  // Per-channel conditions, asynchronous
  input wire logic [`CISE_NUM_CH-1:0] fifo_limit_alarm,
  input wire logic [`CISE_NUM_CH-1:0] receive_lock_lost,
  input wire logic [`CISE_NUM_CH-1:0] receive_signal_lost,
  input wire logic [`CISE_NUM_CH-1:0] transmit_drive_monitor,
  // Interrupt requests toward block level
  output logic [`CISE_NUM_CH-1:0] channel_irq
);

  // =====================================================
  // Register map
  // Enable registers, one per channel
  localparam logic [`CISE_ADDR_W-1:0] EN_ADDR [`CISE_NUM_CH] = '{
    `CISE_EN_CH0_ADDR,
    `CISE_EN_CH1_ADDR,
    `CISE_EN_CH2_ADDR
  };
  // Status registers, one per channel
  localparam logic [`CISE_ADDR_W-1:0] ST_ADDR [`CISE_NUM_CH] = '{
    `CISE_ST_CH0_ADDR,
    `CISE_ST_CH1_ADDR,
    `CISE_ST_CH2_ADDR
  };

  // =====================================================
  // Internal signals
  // Channel state
  cise_pkg::cise_src_t enable [`CISE_NUM_CH];
  cise_pkg::cise_src_t status [`CISE_NUM_CH];
  wire [`CISE_NUM_CH-1:0] irq_ch;

  // Address decode, one bit per channel
  wire [`CISE_NUM_CH-1:0] en_hit;
  wire [`CISE_NUM_CH-1:0] st_hit;
  wire [`CISE_NUM_CH-1:0] en_wr_sel;
  wire [`CISE_NUM_CH-1:0] st_rd_sel;
  logic rd_en_hit;
  logic rd_st_hit;

  // Read path
  wire cise_pkg::cise_src_t en_view [`CISE_NUM_CH];
  wire cise_pkg::cise_src_t st_view [`CISE_NUM_CH];
  cise_pkg::cise_src_t en_rd_nib;
  cise_pkg::cise_src_t st_rd_nib;
  cise_pkg::cise_src_t wr_nib;
  cise_pkg::cise_byte_t rdata_d;

  // =====================================================
  // Write data, only the enable bits are stored
  assign wr_nib = reg_wdata[`CISE_NUM_SRC-1:0];

  // =====================================================
  // Per-channel logic
  genvar g;
  genvar k;
  generate
    for (g = 0; g < `CISE_NUM_CH; g++) begin : g_ch
      // Raw pins and filtered conditions of this channel
      wire cise_pkg::cise_src_t raw;
      wire cise_pkg::cise_src_t sync_bits;

      // =====================================================
      // Condition pins in register bit order
      assign raw[`CISE_BIT_FIFO_LIMIT] = fifo_limit_alarm[g];
      assign raw[`CISE_BIT_LOCK_LOST] = receive_lock_lost[g];
      assign raw[`CISE_BIT_SIGNAL_LOST] = receive_signal_lost[g];
      assign raw[`CISE_BIT_DRIVE_MON] = transmit_drive_monitor[g];

      // =====================================================
      // Address decode for this channel
      assign en_hit[g] = (reg_addr == EN_ADDR[g]);
      assign st_hit[g] = (reg_addr == ST_ADDR[g]);
      assign en_wr_sel[g] = reg_wr && en_hit[g];
      assign st_rd_sel[g] = reg_rd && st_hit[g];

      // =====================================================
      // Three-stage synchroniser per condition bit
      for (k = 0; k < `CISE_NUM_SRC; k++) begin : g_bit
        // Pipeline for one condition bit
        logic s1_q;
        logic s2_q;
        logic s3_q;
        logic filt_q;

        // Stage one, may settle late
        always_ff @(posedge clk or negedge rst_b) begin
          if (!rst_b) begin
            s1_q <= `CISE_COND_IDLE;
          end else begin
            s1_q <= raw[k];
          end
        end

        // Stage two, first settled copy
        always_ff @(posedge clk or negedge rst_b) begin
          if (!rst_b) begin
            s2_q <= `CISE_COND_IDLE;
          end else begin
            s2_q <= s1_q;
          end
        end

        // Stage three, compared with stage two
        always_ff @(posedge clk or negedge rst_b) begin
          if (!rst_b) begin
            s3_q <= `CISE_COND_IDLE;
          end else begin
            s3_q <= s2_q;
          end
        end

        // Taken only once stages two and three agree
        always_ff @(posedge clk or negedge rst_b) begin
          if (!rst_b) begin
            filt_q <= `CISE_COND_IDLE;
          end else if (s2_q == s3_q) begin
            filt_q <= s3_q;
          end else begin
            filt_q <= filt_q;
          end
        end

        assign sync_bits[k] = filt_q;
      end

      // =====================================================
      // Enable, change detection and status
      cise_channel u_ch (
        .clk(clk),
        .rst_b(rst_b),
        .en_wr(en_wr_sel[g]),
        .en_wdata(wr_nib),
        .st_rd(st_rd_sel[g]),
        .cond(sync_bits),
        .enable(enable[g]),
        .status(status[g]),
        .irq(irq_ch[g])
      );

      // =====================================================
      // Read contribution, zero unless addressed
      assign en_view[g] = en_hit[g] ? enable[g] : `CISE_EN_RESET;
      assign st_view[g] = st_hit[g] ? status[g] : `CISE_ST_RESET;
    end
  endgenerate

  // =====================================================
  // Interrupt requests toward block level
  assign channel_irq = irq_ch;

  // =====================================================
  // Register group hit by the address
  assign rd_en_hit = |en_hit;
  assign rd_st_hit = |st_hit;

  // =====================================================
  // Enable read view
  always_comb begin
    en_rd_nib = `CISE_EN_RESET;
    for (int i = 0; i < `CISE_NUM_CH; i++) begin
      en_rd_nib = en_rd_nib | en_view[i];
    end
  end

  // =====================================================
  // Status read view
  always_comb begin
    st_rd_nib = `CISE_ST_RESET;
    for (int i = 0; i < `CISE_NUM_CH; i++) begin
      st_rd_nib = st_rd_nib | st_view[i];
    end
  end

  // =====================================================
  // Read data select, unmapped addresses read zero
  always_comb begin
    if (rd_en_hit) begin
      rdata_d = {`CISE_UPPER_ZERO, en_rd_nib};
    end else if (rd_st_hit) begin
      rdata_d = {`CISE_UPPER_ZERO, st_rd_nib};
    end else begin
      rdata_d = `CISE_RD_UNMAPPED;
    end
  end

  // =====================================================
  // Read data register, holds between reads
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= `CISE_RD_UNMAPPED;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end

endmodule

// >>> sim/channel_interrupt_source_enable_test.sv
// Random and corner tests of enables, change flags and requests.
// Assumes design files and cise_monitor compiled first.
`timescale 1ns/1ps
module channel_interrupt_source_enable_test;
  logic clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
  logic [5:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, wd;
  logic [11:0] cv = 0;
  logic [2:0] channel_irq;
  int err_total = 0, n_compared = 0, c, b;
  always #12.5 clk = ~clk;
  cise_top u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fifo_limit_alarm(cv[11:9]), .receive_lock_lost(cv[8:6]),
    .receive_signal_lost(cv[5:3]), .transmit_drive_monitor(cv[2:0]), .channel_irq(channel_irq));
  function automatic logic [2:0] irq_exp(int ch, logic en);
    return 3'(en) << ch;
  endfunction
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [5:0] a, logic [7:0] d);
    @(posedge clk) #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge clk) #1 reg_wr = 0;
  endtask
  task automatic rd(logic [5:0] a, logic [7:0] e);
    @(posedge clk) #1 {reg_rd, reg_addr} = {1'b1, a};
    @(posedge clk) #1 reg_rd = 0;
    chk("rdata", reg_rdata, e);
  endtask
  task automatic final_report;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ====================
  // Stimulus
  initial begin
    void'($urandom(64));
    repeat (10) @(posedge clk);
    #1 rst_b = 1;
    for (int i = 0; i < 3; i++) begin
      rd(6'h01 + 6'(8 * i), 8'h00);
      rd(6'h02 + 6'(8 * i), 8'h00);
    end
    rd(6'h3f, 8'h00);
    for (int i = 0; i < 24; i++) begin
      c = (i / 4) % 3;
      b = i % 4;
      wd = 8'($urandom);
      wd[b] = i >= 12;
      wr(6'h01 + 6'(8 * c), wd);
      rd(6'h01 + 6'(8 * c), wd & 8'h0f);
      cv[3 * b + c] = ~cv[3 * b + c];
      repeat (8) @(posedge clk);
      #1 chk("irq", 8'(channel_irq), 8'(irq_exp(c, wd[b])));
      rd(6'h02 + 6'(8 * c), 8'h01 << b);
      rd(6'h02 + 6'(8 * c), 8'h00);
    end
    for (int i = 0; i < 3; i++) begin
      wr(6'h01 + 6'(8 * i), 8'hf0);
      rd(6'h01 + 6'(8 * i), 8'h00);
    end
    final_report;
  end
  // Hang guard
  initial begin
    #75000;
    err_total++;
    final_report;
  end
endmodule
bind cise_top cise_monitor u_mon (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fifo_limit_alarm(fifo_limit_alarm),
  .receive_lock_lost(receive_lock_lost), .receive_signal_lost(receive_signal_lost),
  .transmit_drive_monitor(transmit_drive_monitor), .channel_irq(channel_irq));

// >>> sim/cise_monitor.sv
// Port checker for the channel source interrupt top.
// Assumes binding to cise_top with one clock domain.
`timescale 1ns/1ps
module cise_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Conditions and requests
  input wire logic [2:0] fifo_limit_alarm,
  input wire logic [2:0] receive_lock_lost,
  input wire logic [2:0] receive_signal_lost,
  input wire logic [2:0] transmit_drive_monitor,
  input wire logic [2:0] channel_irq
);
  wire [11:0] cnd = {fifo_limit_alarm, receive_lock_lost, receive_signal_lost, transmit_drive_monitor};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ====================
  // Assertions
  property p_unmap; reg_rd && reg_addr == 6'h3f |=> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_upper; reg_rd |=> reg_rdata[7:4] == 4'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper bits not zero");
  property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_off0; reg_wr && reg_addr == 6'h01 && reg_wdata[3:0] == 4'h0 |=> !channel_irq[0]; endproperty
  a_off0: assert property (p_off0) else $error("channel 0 request while disabled");
  property p_off1; reg_wr && reg_addr == 6'h09 && reg_wdata[3:0] == 4'h0 |=> !channel_irq[1]; endproperty
  a_off1: assert property (p_off1) else $error("channel 1 request while disabled");
  property p_off2; reg_wr && reg_addr == 6'h11 && reg_wdata[3:0] == 4'h0 |=> !channel_irq[2]; endproperty
  a_off2: assert property (p_off2) else $error("channel 2 request while disabled");
  property p_clr; ($stable(cnd))[*8] ##0 (reg_rd && reg_addr == 6'h02) |=> !channel_irq[0]; endproperty
  a_clr: assert property (p_clr) else $error("status not cleared by read");
  property p_quiet; (!reg_wr && !reg_rd && $stable(cnd))[*8] |=> $stable(channel_irq); endproperty
  a_quiet: assert property (p_quiet) else $error("request moved without cause");
  c_irq0: cover property ($rose(channel_irq[0]));
  c_irq1: cover property ($rose(channel_irq[1]));
  c_irq2: cover property ($rose(channel_irq[2]));
endmodule
